// File: shared/nand_host_pkg.sv
package nand_host_pkg;
  // array geometry
  localparam int BLOCK_COUNT    = 1024;
  localparam int PAGES_PER_BLK  = 64;
  localparam int PAGE_BYTES     = 2112;
  localparam int MAIN_BYTES     = 2048;
  localparam int SPARE_BYTES    = 64;
  localparam int ADDR_CYCLES    = 4;
  // bus timing, given in ns and rounded up to sys_clk cycles (25 ns each)
  localparam int CLK_PERIOD_NS  = 25;
  localparam int STROBE_LOW_NS  = 25;
  localparam int STROBE_HIGH_NS = 25;
  localparam int STROBE_LOW_CYC = (STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_HI_CYC  = (STROBE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] LOW_CNT  = 4'(STROBE_LOW_CYC);
  localparam logic [3:0] HIGH_CNT = 4'(STROBE_HI_CYC);
  // reset values
  localparam logic [7:0] IO_RESET = 8'h00;
  // host request kinds
  typedef enum logic [1:0] {
    REQ_CMD,
    REQ_ADDR,
    REQ_WDATA,
    REQ_RDATA
  } req_kind_e;
endpackage

// File: design/nand_host.sv
module nand_host
(
  // clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 reset_n,
  input  wire logic                 clkEn,
  // user request
  input  wire logic                 reqValid,
  input  wire nand_host_pkg::req_kind_e reqKind,
  input  wire logic [7:0]           reqByte,
  input  wire logic                 reqLast,
  input  wire logic                 protectReq,
  output logic                      reqReady,
  output logic                      rspValid,
  output logic [7:0]                rspByte,
  output logic                      devReady,
  // device pins
  output logic                      chipSelect_n,
  output logic                      cmdLatch,
  output logic                      addrLatch,
  output logic                      writeStrobe_n,
  output logic                      read_strobe_n,
  output logic                      writeProtect_n,
  output logic [7:0]                ioBusOut,
  output logic                      ioBusOe,
  input  wire logic [7:0]           io_bus,
  input  wire logic                 ready_busy_n
);
  import nand_host_pkg::*;

  typedef enum logic [1:0] {IDLE, LOW, HIGH} phase_e;

  phase_e     phase_ff;
  req_kind_e  kind_ff;
  logic [3:0] cnt_ff;
  logic       last_ff;
  logic       rdySync_ff;
  logic [1:0] addrCnt_ff;

  logic take;
  assign take = clkEn && reqValid && reqReady;

  // sequencer: one strobe low phase then high phase per byte
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      phase_ff <= IDLE;
      kind_ff  <= REQ_CMD;
      cnt_ff   <= 4'h0;
      last_ff  <= 1'b1;
    end else if (clkEn) begin
      unique case (phase_ff)
        IDLE: begin
          if (take) begin
            phase_ff <= LOW;
            kind_ff  <= reqKind;
            last_ff  <= reqLast;
            cnt_ff   <= LOW_CNT;
          end
        end
        LOW: begin
          if (cnt_ff == 4'h1) begin
            phase_ff <= HIGH;
            cnt_ff   <= HIGH_CNT;
          end else begin
            cnt_ff <= cnt_ff - 4'h1;
          end
        end
        HIGH: begin
          if (cnt_ff == 4'h1) begin
            phase_ff <= IDLE;
          end else begin
            cnt_ff <= cnt_ff - 4'h1;
          end
        end
      endcase
    end
  end

  // ready only when idle and device not busy; busy blocks new frames
  // pins are synchronous, so the first stage already gives a settled busy level
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      reqReady   <= 1'b0;
      rdySync_ff <= 1'b0;
      devReady   <= 1'b0;
    end else if (clkEn) begin
      rdySync_ff <= ready_busy_n;
      devReady   <= rdySync_ff;
      reqReady   <= (phase_ff == IDLE) && !take && rdySync_ff;
    end
  end

  // pin drive: latches set on the same edge the strobe falls, held through rising edge
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      chipSelect_n  <= 1'b1;
      cmdLatch      <= 1'b0;
      addrLatch     <= 1'b0;
      writeStrobe_n <= 1'b1;
      read_strobe_n <= 1'b1;
      ioBusOut      <= IO_RESET;
      ioBusOe       <= 1'b0;
    end else if (clkEn) begin
      if (take) begin
        chipSelect_n  <= 1'b0;
        cmdLatch      <= (reqKind == REQ_CMD);
        addrLatch     <= (reqKind == REQ_ADDR);
        writeStrobe_n <= (reqKind == REQ_RDATA);
        read_strobe_n <= (reqKind != REQ_RDATA);
        ioBusOut      <= (reqKind == REQ_ADDR && addrCnt_ff == 2'h1) ?
                         {4'h0, reqByte[3:0]} : reqByte;
        ioBusOe       <= (reqKind != REQ_RDATA);
      end else if (phase_ff == LOW && cnt_ff == 4'h1) begin
        writeStrobe_n <= 1'b1; // rising edge captures the byte
        read_strobe_n <= 1'b1;
      end else if (phase_ff == HIGH && cnt_ff == 4'h1) begin
        cmdLatch  <= 1'b0;
        addrLatch <= 1'b0;
        ioBusOe   <= 1'b0;
        if (last_ff) begin
          chipSelect_n <= 1'b1;
        end
      end
    end
  end

  // address cycle counter, restarted by any command byte
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      addrCnt_ff <= 2'h0;
    end else if (clkEn && take) begin
      if (reqKind == REQ_ADDR) begin
        addrCnt_ff <= addrCnt_ff + 2'h1;
      end else begin
        addrCnt_ff <= 2'h0;
      end
    end
  end

  // read data sampled just before read strobe rises
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rspValid <= 1'b0;
      rspByte  <= IO_RESET;
    end else if (clkEn) begin
      rspValid <= 1'b0;
      if (phase_ff == LOW && cnt_ff == 4'h1 && kind_ff == REQ_RDATA) begin
        rspValid <= 1'b1;
        rspByte  <= io_bus;
      end
    end
  end

  // write protect follows the user, default protected
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      writeProtect_n <= 1'b0;
    end else if (clkEn) begin
      writeProtect_n <= !protectReq;
    end
  end

  // pin protocol checks; the strobe phases are one enabled cycle each,
  // so a longer phase setting must revisit the one-cycle checks below
  AST_EXCL: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !(cmdLatch && addrLatch))
    else $error("both latch strobes high");
  AST_WSTROBE_CS: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !writeStrobe_n |-> !chipSelect_n)
    else $error("write strobe without select");
  AST_RSTROBE_CS: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !read_strobe_n |-> !chipSelect_n && !ioBusOe)
    else $error("read strobe with bus driven");
  AST_HOLD: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !writeStrobe_n |=> $stable(ioBusOut) && $stable(ioBusOe))
    else $error("data changed under write strobe");
  AST_RISE_OE: assert property (@(posedge sys_clk) disable iff (!reset_n)
    $rose(writeStrobe_n) |-> ioBusOe)
    else $error("bus released at strobe rise");
  AST_ADDR_LATCH: assert property (@(posedge sys_clk) disable iff (!reset_n)
    $rose(writeStrobe_n) && $past(addrLatch) |-> addrLatch)
    else $error("address latch dropped early");
  AST_NIBBLE: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (clkEn && take && reqKind == REQ_ADDR && addrCnt_ff == 2'h1) |=> ioBusOut[7:4] == 4'h0)
    else $error("second address cycle high nibble set");
  AST_BUSY: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !devReady |-> !reqReady)
    else $error("request accepted while busy");
  AST_IDLE_CS: assert property (@(posedge sys_clk) disable iff (!reset_n)
    chipSelect_n |-> writeStrobe_n && read_strobe_n && !ioBusOe)
    else $error("activity while deselected");
  AST_WSTROBE_ONE: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (!writeStrobe_n && clkEn) |=> writeStrobe_n)
    else $error("write strobe low too long");
  AST_LATCH_OE: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (cmdLatch || addrLatch) |-> ioBusOe)
    else $error("latch strobe without bus drive");
  AST_CMD_LATCH: assert property (@(posedge sys_clk) disable iff (!reset_n)
    $rose(writeStrobe_n) |-> $stable(cmdLatch) && $stable(addrLatch))
    else $error("latch strobe moved at write rise");
  AST_RDATA: assert property (@(posedge sys_clk) disable iff (!reset_n)
    $rose(read_strobe_n) |-> rspValid)
    else $error("read byte not captured at strobe rise");
  AST_NIBBLE_BUS: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (ioBusOe && addrLatch && addrCnt_ff == 2'h2) |-> ioBusOut[7:4] == 4'h0)
    else $error("column high byte drives upper nibble");
endmodule

// File: verification/nand_dev_model.sv
module nand_dev_model
  import nand_host_pkg::*;
(
  // host pins
  input  wire logic       chipSelect_n,
  input  wire logic       cmdLatch,
  input  wire logic       addrLatch,
  input  wire logic       writeStrobe_n,
  input  wire logic       read_strobe_n,
  input  wire logic       writeProtect_n,
  input  wire logic [7:0] ioBusOut,
  input  wire logic       ioBusOe,
  // resolved bus and busy pull-down
  output logic [7:0]      io_bus,
  output logic            busyPull
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0]  cmdReg;
  logic [7:0]  dout;
  logic [7:0]  lastVal = 8'h00;
  logic [7:0]  addrReg [4];
  logic [11:0] col = 12'h000;
  logic [1:0]  nAddr = 2'h0;
  logic        doe = 1'b0;
  initial busyPull = 1'b0;
  // a released bus shows the inverse of its last value, never a stale copy
  assign io_bus = ioBusOe ? ioBusOut : (doe && !chipSelect_n) ? dout : ~lastVal;
  always @(negedge ioBusOe) lastVal = ioBusOut;
  always @(negedge doe) lastVal = dout;
  // bytes land on the write strobe rising edge while selected
  always @(posedge writeStrobe_n) begin
    if (!chipSelect_n && cmdLatch) begin
      cmdReg = ioBusOut;
      nAddr = 2'h0;
      if (ioBusOut == 8'h30 || (ioBusOut == 8'h10 && writeProtect_n)) begin
        busyPull = 1'b1;
        #500 busyPull = 1'b0;
      end
    end else if (!chipSelect_n && addrLatch) begin
      addrReg[nAddr] = ioBusOut;
      if (nAddr == 2'h1)
        col = {addrReg[1][3:0], addrReg[0]};
      nAddr = nAddr + 2'h1;
    end
  end
  // one column per read pulse, wrapping at the page end; deselected pulses are ignored
  always @(negedge read_strobe_n) begin
    if (!chipSelect_n) begin
      #5 dout = col[7:0] ^ 8'h5A;
      doe = 1'b1;
    end
  end
  always @(posedge read_strobe_n) begin
    if (!chipSelect_n) begin
      col = (col == 12'(PAGE_BYTES - 1)) ? 12'h000 : col + 12'h001;
      #10 doe = 1'b0;
    end
  end
endmodule

// File: verification/test_nand_host.sv
module test_nand_host;
  timeunit 1ns;
  timeprecision 100ps;
  import nand_host_pkg::*;
  logic sys_clk = 0, reset_n = 0, reqValid = 0, reqLast = 0, protectReq = 1, clkEn = 1;
  logic [7:0] reqByte = 8'h00, rspByte, ioBusOut, io_bus;
  req_kind_e  reqKind = REQ_CMD;
  logic reqReady, rspValid, devReady, chipSelect_n, cmdLatch, addrLatch, writeStrobe_n;
  logic read_strobe_n, writeProtect_n, ioBusOe, busyPull;
  wire  ready_busy_n = busyPull ? 1'b0 : 1'b1; // external pull-up
  int   n_errors = 0, checked = 0, cycles = 0;
  always #12.5 sys_clk = ~sys_clk;
  nand_host i_dut (.sys_clk(sys_clk), .reset_n(reset_n), .clkEn(clkEn), .reqValid(reqValid),
    .reqKind(reqKind), .reqByte(reqByte), .reqLast(reqLast), .protectReq(protectReq),
    .reqReady(reqReady), .rspValid(rspValid), .rspByte(rspByte), .devReady(devReady),
    .chipSelect_n(chipSelect_n), .cmdLatch(cmdLatch), .addrLatch(addrLatch),
    .writeStrobe_n(writeStrobe_n), .read_strobe_n(read_strobe_n),
    .writeProtect_n(writeProtect_n), .ioBusOut(ioBusOut), .ioBusOe(ioBusOe),
    .io_bus(io_bus), .ready_busy_n(ready_busy_n));
  nand_dev_model u_dev (.chipSelect_n(chipSelect_n), .cmdLatch(cmdLatch),
    .addrLatch(addrLatch), .writeStrobe_n(writeStrobe_n), .read_strobe_n(read_strobe_n),
    .writeProtect_n(writeProtect_n), .ioBusOut(ioBusOut), .ioBusOe(ioBusOe),
    .io_bus(io_bus), .busyPull(busyPull));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    $display("checks=%0d errors=%0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // request is held until the edge that samples reqReady high
  task automatic send(input req_kind_e k, input logic [7:0] b, input logic l);
    @(posedge sys_clk);
    reqValid <= 1'b1;
    reqKind <= k;
    reqByte <= b;
    reqLast <= l;
    do @(posedge sys_clk); while (reqReady !== 1'b1);
    reqValid <= 1'b0;
  endtask
  task automatic cmdAddr(input logic [7:0] c);
    logic [7:0] a[4] = '{8'hFE, 8'hF0, 8'h05, 8'h00};
    send(REQ_CMD, c, 1'b0);
    foreach (a[i]) send(REQ_ADDR, a[i], 1'b0);
  endtask
  task automatic t_reset;
    @(negedge sys_clk);
    check({5'h00, chipSelect_n, ioBusOe, writeProtect_n}, 8'h04);
    $display("done reset");
  endtask
  // a low clock enable must freeze a command byte mid-strobe
  task automatic t_freeze;
    send(REQ_CMD, 8'hFF, 1'b1);
    clkEn <= 1'b0;
    repeat (3) @(negedge sys_clk);
    check({6'h00, cmdLatch, writeStrobe_n}, 8'h02);
    @(posedge sys_clk);
    clkEn <= 1'b1;
    repeat (4) @(negedge sys_clk);
    check(u_dev.cmdReg, 8'hFF);
    check({7'h00, chipSelect_n}, 8'h01);
    $display("done freeze");
  endtask
  // page read: busy, then three bytes across a column carry
  task automatic t_read;
    cmdAddr(8'h00);
    send(REQ_CMD, 8'h30, 1'b0);
    repeat (4) @(negedge sys_clk);
    check({7'h00, devReady}, 8'h00);
    check(u_dev.addrReg[1], 8'h00);
    check(u_dev.cmdReg, 8'h30);
    for (int i = 0; i < 3; i++) begin
      send(REQ_RDATA, 8'h00, i == 2);
      do @(negedge sys_clk); while (rspValid !== 1'b1);
      check(rspByte, 8'(12'h0FE + i) ^ 8'h5A);
    end
    $display("done read");
  endtask
  // program with protection on must never make the device busy
  task automatic t_prog(input logic wp);
    @(posedge sys_clk);
    protectReq <= wp;
    cmdAddr(8'h80);
    send(REQ_WDATA, 8'h3C, 1'b0);
    send(REQ_CMD, 8'h10, 1'b1);
    repeat (4) @(negedge sys_clk);
    check({7'h00, devReady}, {7'h00, wp});
    check({7'h00, writeProtect_n}, {7'h00, ~wp});
    $display("done program");
  endtask
  // hang guard, far above the fewer than two hundred cycles the tests need
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      final_report;
    end
  end
  initial begin
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    t_reset;
    t_freeze;
    t_read;
    t_prog(1'b1);
    t_prog(1'b0);
    final_report;
  end
endmodule
